// ---- addsub_adder.sv ----
// Carry-in adder with carry-out and signed overflow
`include "addsub_params.svh"
module addsub_adder
(
   addsub_core_if.core bus
);
   logic [`DATA_W:0] wide;
   assign wide     = {1'b0, bus.a} + {1'b0, bus.b} + {{`DATA_W{1'b0}}, bus.cin};
   assign bus.sum  = wide[`DATA_W-1:0];
   assign bus.cout = wide[`DATA_W];
   // Overflow when both inputs share a sign that the sum does not
   assign bus.ovf  = (bus.a[`DATA_W-1] == bus.b[`DATA_W-1])
                   && (bus.sum[`DATA_W-1] != bus.a[`DATA_W-1]);
endmodule

// ---- addsub_core_if.sv ----
// Operand and result bundle between the control stage and the adder core
`include "addsub_params.svh"
interface addsub_core_if;
   logic [`DATA_W-1:0] a;
   logic [`DATA_W-1:0] b;
   logic               cin;
   logic [`DATA_W-1:0] sum;
   logic               cout;
   logic               ovf;
   modport ctrl (output a, b, cin, input sum, cout, ovf);
   modport core (input a, b, cin, output sum, cout, ovf);
endinterface

// ---- addsub_datapath.sv ----
// Add, subtract and carry datapath with flag update and branch target
`include "addsub_params.svh"
// Functional notes
// - Add yields the first operand plus the flexible second operand or a 12-bit immediate.
// - Add with carry adds the first operand, the second operand and the carry flag.
// - Subtract yields the first operand minus the second operand or the 12-bit immediate.
// - Subtract with carry takes one more away when the carry flag is clear.
// - Reverse subtract yields the second operand minus the first operand.
// - The wide immediate forms act exactly as the 12-bit immediate add and subtract.
// - With flag setting all four flags follow the result, otherwise they hold.
// - A program counter first operand has its two low bits taken as zero; the second operand is used unaligned.
// - Add writing the program counter branches to the sum with bit zero cleared.
module addsub_datapath
   import addsub_pkg::*;
(
   input  wire logic                    CLK_I,
   input  wire logic                    ARST_N_I,
   input  wire logic                    VALID_I,
   input  wire arith_op_e               OP_I,
   input  wire logic                    USE_IMM_I,
   input  wire logic [`IMM_W-1:0]       IMM_I,
   input  wire logic                    SET_FLAGS_I,
   input  wire logic                    COND_PASS_I,
   input  wire logic                    HAS_DEST_I,
   input  wire logic [`REG_IDX_W-1:0]   DEST_IDX_I,
   input  wire logic [`REG_IDX_W-1:0]   FIRST_IDX_I,
   input  wire logic [`DATA_W-1:0]      FIRST_VAL_I,
   input  wire logic [`DATA_W-1:0]      SECOND_VAL_I,
   output logic                         WR_EN_O,
   output logic [`REG_IDX_W-1:0]        WR_IDX_O,
   output logic [`DATA_W-1:0]           RESULT_O,
   output logic                         BRANCH_O,
   output logic [`DATA_W-1:0]           BRANCH_ADDR_O,
   output logic                         FLAG_N_O,
   output logic                         FLAG_Z_O,
   output logic                         FLAG_C_O,
   output logic                         FLAG_V_O
);
   addsub_core_if core_bus ();
   addsub_adder u_adder (.bus(core_bus));

   logic [`DATA_W-1:0]     first_op;
   logic [`DATA_W-1:0]     second_op;
   logic [`REG_IDX_W-1:0]  dest_idx;
   logic                   exec;
   logic                   pc_dest;
   logic                   carry_reg;
   logic                   overflow_reg;
   stage_e                 stage_reg;
   stage_e                 stage_next;

   // Program counter base is word aligned before use
   assign first_op  = (FIRST_IDX_I == `PC_IDX) ? (FIRST_VAL_I & `PC_ALIGN_MSK)
                                                : FIRST_VAL_I;
   // Immediate form shared by plain and wide encodings
   assign second_op = USE_IMM_I ? {{(`DATA_W-`IMM_W){1'b0}}, IMM_I}
                                : SECOND_VAL_I;
   assign dest_idx  = HAS_DEST_I ? DEST_IDX_I : FIRST_IDX_I;
   assign exec      = VALID_I && COND_PASS_I;
   assign pc_dest   = (dest_idx == `PC_IDX) && (OP_I == OP_ADD);

   // Subtraction is a plus not-b plus carry-in
   always_comb
   begin
      core_bus.a   = first_op;
      core_bus.b   = second_op;
      core_bus.cin = 1'b0;
      case (OP_I)
         OP_ADD:
         begin
            core_bus.cin = 1'b0;
         end
         OP_ADD_CARRY:
         begin
            core_bus.cin = carry_reg;
         end
         OP_SUB:
         begin
            core_bus.b   = ~second_op;
            core_bus.cin = 1'b1;
         end
         OP_SUBTRACT_WITH_CARRY:
         begin
            core_bus.b   = ~second_op;
            core_bus.cin = carry_reg;
         end
         OP_REVERSE_SUBTRACT:
         begin
            core_bus.a   = second_op;
            core_bus.b   = ~first_op;
            core_bus.cin = 1'b1;
         end
         default:
         begin
            core_bus.cin = 1'b0;
         end
      endcase
   end

   always_comb
   begin
      stage_next = exec ? ST_RESULT : ST_IDLE;
   end

   always_ff @(posedge CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
         stage_reg <= ST_IDLE;
      else
         stage_reg <= stage_next;
   end

   // Result write-back
   always_ff @(posedge CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         WR_EN_O  <= 1'b0;
         WR_IDX_O <= '0;
         RESULT_O <= '0;
      end
      else
      begin
         WR_EN_O <= exec && !pc_dest;
         if (exec)
         begin
            WR_IDX_O <= dest_idx;
            RESULT_O <= core_bus.sum;
         end
      end
   end

   // Branch through program counter add
   always_ff @(posedge CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         BRANCH_O      <= 1'b0;
         BRANCH_ADDR_O <= '0;
      end
      else
      begin
         BRANCH_O <= exec && pc_dest;
         if (exec && pc_dest)
            BRANCH_ADDR_O <= core_bus.sum & `BRANCH_MSK;
      end
   end

   // Flag update
   always_ff @(posedge CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         FLAG_N_O     <= 1'b0;
         FLAG_Z_O     <= 1'b0;
         carry_reg    <= 1'b0;
         overflow_reg <= 1'b0;
      end
      else if (exec && SET_FLAGS_I)
      begin
         FLAG_N_O     <= core_bus.sum[`DATA_W-1];
         FLAG_Z_O     <= (core_bus.sum == '0);
         carry_reg    <= core_bus.cout;
         overflow_reg <= core_bus.ovf;
      end
   end
   assign FLAG_C_O = carry_reg;
   assign FLAG_V_O = overflow_reg;

   logic [`DATA_W:0] ref_add;
   assign ref_add = {1'b0, first_op} + {1'b0, second_op};

   plain_add_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
      (exec && OP_I == OP_ADD && !pc_dest) |=> RESULT_O == $past(ref_add[`DATA_W-1:0]))
      else $error("add result wrong");
   add_carry_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
      (exec && OP_I == OP_ADD_CARRY) |=>
      RESULT_O == $past(first_op + second_op + {31'h0, carry_reg}))
      else $error("add with carry wrong");
   sub_value_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
      (exec && OP_I == OP_SUB) |=> RESULT_O == $past(first_op - second_op))
      else $error("subtract wrong");
   sub_carry_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
      (exec && OP_I == OP_SUBTRACT_WITH_CARRY) |=>
      RESULT_O == $past(first_op - second_op - {31'h0, !carry_reg}))
      else $error("subtract with carry wrong");
   rev_sub_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
      (exec && OP_I == OP_REVERSE_SUBTRACT) |=> RESULT_O == $past(second_op - first_op))
      else $error("reverse subtract wrong");
   flags_hold_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
      !(exec && SET_FLAGS_I) |=> $stable(FLAG_N_O) && $stable(FLAG_Z_O)
      && $stable(FLAG_C_O) && $stable(FLAG_V_O))
      else $error("flags changed without update");
   borrow_carry_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
      (exec && SET_FLAGS_I && OP_I == OP_SUB) |=> FLAG_C_O == $past(first_op >= second_op))
      else $error("borrow carry wrong");
   pc_align_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
      (exec && FIRST_IDX_I == `PC_IDX && OP_I == OP_ADD && USE_IMM_I && !pc_dest)
      |=> RESULT_O == $past((FIRST_VAL_I & `PC_ALIGN_MSK) + {20'h0, IMM_I}))
      else $error("pc base not aligned");
   branch_bit_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
      BRANCH_O |-> BRANCH_ADDR_O[0] == 1'b0 && !WR_EN_O)
      else $error("branch target bit zero set");
   no_write_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
      (VALID_I && !COND_PASS_I) |=> !WR_EN_O && !BRANCH_O)
      else $error("failed condition wrote");
   default_dest_a: assert property (@(posedge CLK_I) disable iff (!ARST_N_I)
      (exec && !HAS_DEST_I) |=> WR_IDX_O == $past(FIRST_IDX_I))
      else $error("default destination wrong");

   add_seen_c: cover property (@(posedge CLK_I) exec && OP_I == OP_ADD && SET_FLAGS_I);
   sub_carry_seen_c: cover property (@(posedge CLK_I) exec && OP_I == OP_SUBTRACT_WITH_CARRY);
   branch_seen_c: cover property (@(posedge CLK_I) BRANCH_O);
   skip_seen_c: cover property (@(posedge CLK_I) VALID_I && !COND_PASS_I);
   stage_seen_c: cover property (@(posedge CLK_I) stage_reg == ST_RESULT);
endmodule

// ---- addsub_params.svh ----
// Constants for the add and subtract datapath
`ifndef ADDSUB_PARAMS_SVH
`define ADDSUB_PARAMS_SVH
`define DATA_W       32
`define REG_IDX_W    4
`define IMM_W        12
`define SP_IDX       4'hd
`define PC_IDX       4'hf
`define PC_ALIGN_MSK 32'hffff_fffc
`define BRANCH_MSK   32'hffff_fffe
`endif

// ---- addsub_pkg.sv ----
// Types for the add and subtract datapath
package addsub_pkg;
   typedef enum logic [2:0] {
      OP_ADD,
      OP_ADD_CARRY,
      OP_SUB,
      OP_SUBTRACT_WITH_CARRY,
      OP_REVERSE_SUBTRACT
   } arith_op_e;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_RESULT
   } stage_e;
endpackage

// ---- regfile_model.sv ----
// Register file model that feeds the first operand and takes write-backs
module regfile_model
(
   input  wire logic        clk_i,
   input  wire logic        wr_en_i,
   input  wire logic [3:0]  wr_idx_i,
   input  wire logic [31:0] wr_data_i,
   input  wire logic        ld_en_i,
   input  wire logic [31:0] ld_val_i,
   input  wire logic [3:0]  rd_idx_i,
   output logic      [31:0] rd_val_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] regs [16];
   // Preload wins over a write-back in the same cycle
   always_ff @(posedge clk_i)
   begin
      if (ld_en_i)
         regs[rd_idx_i] <= ld_val_i;
      else if (wr_en_i)
         regs[wr_idx_i] <= wr_data_i;
   end
   assign rd_val_o = regs[rd_idx_i];
endmodule

// ---- tb.sv ----
// Self-checking bench for the add and subtract datapath
`include "addsub_params.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb import addsub_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, arst_n, valid, use_imm, set_flags, cond_pass, has_dest, ld_en;
   logic wr_en, branch, fn, fz, fc, fv, en, ez, ec, ev;
   arith_op_e op;
   logic [11:0] imm;
   logic [3:0] dest_idx, first_idx, wr_idx;
   logic [31:0] first_val, second_val, ld_val, result, branch_addr;
   int fail_count, samples_checked;
   addsub_datapath dut (.CLK_I(clk), .ARST_N_I(arst_n), .VALID_I(valid), .OP_I(op),
      .USE_IMM_I(use_imm), .IMM_I(imm), .SET_FLAGS_I(set_flags), .COND_PASS_I(cond_pass),
      .HAS_DEST_I(has_dest), .DEST_IDX_I(dest_idx), .FIRST_IDX_I(first_idx),
      .FIRST_VAL_I(first_val), .SECOND_VAL_I(second_val), .WR_EN_O(wr_en),
      .WR_IDX_O(wr_idx), .RESULT_O(result), .BRANCH_O(branch), .BRANCH_ADDR_O(branch_addr),
      .FLAG_N_O(fn), .FLAG_Z_O(fz), .FLAG_C_O(fc), .FLAG_V_O(fv));
   regfile_model rf (.clk_i(clk), .wr_en_i(wr_en), .wr_idx_i(wr_idx), .wr_data_i(result),
      .ld_en_i(ld_en), .ld_val_i(ld_val), .rd_idx_i(first_idx), .rd_val_o(first_val));
   task automatic close_out();
      $display("Checks %0d, errors %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Preload the first operand, issue one op, then judge outputs and flags
   task automatic run_op(arith_op_e o, logic [3:0] fi, logic [31:0] a, logic [31:0] b,
      logic ui, logic sf, logic cp, logic hd, logic [3:0] di);
      logic [31:0] x, p, q;
      logic [32:0] s;
      logic        ci, brn;
      @(negedge clk);
      `CHK(wr_en | branch, 1'b0)
      ld_en = 1'b1;
      first_idx = fi;
      ld_val = a;
      @(negedge clk);
      ld_en = 1'b0;
      valid = 1'b1;
      op = o;
      use_imm = ui;
      imm = b[11:0];
      second_val = ui ? ~b : b;
      set_flags = sf;
      cond_pass = cp;
      has_dest = hd;
      dest_idx = di;
      x = (fi == `PC_IDX) ? (a & `PC_ALIGN_MSK) : a;
      p = (o == OP_REVERSE_SUBTRACT) ? b : x;
      q = (o == OP_SUB || o == OP_SUBTRACT_WITH_CARRY) ? ~b
        : (o == OP_REVERSE_SUBTRACT ? ~x : b);
      ci = (o == OP_SUB || o == OP_REVERSE_SUBTRACT) ? 1'b1 : (o == OP_ADD ? 1'b0 : ec);
      s = {1'b0, p} + {1'b0, q} + {32'h0, ci};
      brn = (o == OP_ADD) && ((hd ? di : fi) == `PC_IDX);
      @(negedge clk);
      valid = 1'b0;
      `CHK(wr_en, cp & ~brn)
      `CHK(branch, cp & brn)
      if (cp && !brn)
      begin
         `CHK(wr_idx, hd ? di : fi)
         `CHK(result, s[31:0])
      end
      if (cp && brn)
         `CHK(branch_addr, s[31:0] & `BRANCH_MSK)
      if (cp && sf && !brn)
      begin
         en = s[31];
         ez = (s[31:0] == 32'h0);
         ec = s[32];
         ev = (p[31] == q[31]) && (s[31] != p[31]);
      end
      `CHK({fn, fz, fc, fv}, {en, ez, ec, ev})
   endtask
   task automatic t_add_adc();
      run_op(OP_ADD, 4'h1, 32'hffff_ffff, 32'h1, 0, 1, 1, 1, 4'h2);
      run_op(OP_ADD, 4'h1, 32'h10, 32'hfff, 1, 0, 1, 1, 4'h2);
      run_op(OP_ADD_CARRY, 4'h3, 32'h7fff_ffff, 32'h0, 0, 1, 1, 1, 4'h4);
      run_op(OP_ADD_CARRY, 4'h3, 32'h5, 32'h6, 0, 1, 1, 1, 4'h4);
   endtask
   task automatic t_sub_carry();
      run_op(OP_SUB, 4'h5, 32'h5, 32'h3, 1, 1, 1, 1, 4'h6);
      run_op(OP_SUBTRACT_WITH_CARRY, 4'h5, 32'ha, 32'h3, 0, 1, 1, 1, 4'h6);
      run_op(OP_SUB, 4'h5, 32'h0, 32'h1, 0, 1, 1, 1, 4'h6);
      run_op(OP_SUBTRACT_WITH_CARRY, 4'h5, 32'ha, 32'h3, 0, 1, 1, 1, 4'h6);
      run_op(OP_SUB, 4'h5, 32'h8000_0000, 32'h1, 0, 1, 1, 1, 4'h6);
   endtask
   task automatic t_reverse();
      run_op(OP_REVERSE_SUBTRACT, 4'h4, 32'h5, 32'h500, 0, 1, 1, 1, 4'h4);
      run_op(OP_REVERSE_SUBTRACT, 4'h4, 32'h500, 32'h5, 0, 1, 1, 1, 4'h4);
   endtask
   task automatic t_cond_dest();
      run_op(OP_ADD, 4'h7, 32'hffff_ffff, 32'h1, 0, 1, 0, 1, 4'h8);
      run_op(OP_SUB, `SP_IDX, 32'h2000, 32'h8, 1, 1, 1, 0, 4'h0);
   endtask
   task automatic t_pc();
      run_op(OP_ADD, `PC_IDX, 32'h1003, 32'h4, 1, 0, 1, 1, 4'h9);
      run_op(OP_SUB, `PC_IDX, 32'h1002, 32'hfff, 1, 0, 1, 1, 4'h9);
   endtask
   task automatic t_branch();
      run_op(OP_ADD, `PC_IDX, 32'h2002, 32'h31, 0, 0, 1, 1, `PC_IDX);
      run_op(OP_ADD, `PC_IDX, 32'h2002, 32'h31, 0, 0, 0, 1, `PC_IDX);
   endtask
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial
   begin
      #50000;
      fail_count++;
      close_out();
   end
   initial
   begin
      {arst_n, valid, use_imm, set_flags, cond_pass, has_dest, ld_en} = 7'h0;
      {en, ez, ec, ev} = 4'h0;
      op = OP_ADD;
      {imm, dest_idx, first_idx, second_val, ld_val} = 84'h0;
      repeat (5) @(negedge clk);
      arst_n = 1'b1;
      `CHK({wr_en, branch, result, fn, fz, fc, fv}, 38'h0)
      t_add_adc();
      t_sub_carry();
      t_reverse();
      t_cond_dest();
      t_pc();
      t_branch();
      close_out();
   end
endmodule
